/* File: rtl/mul_div_unit.sv */
`timescale 1ns/100ps
// memory-mapped 16x16 multiplier and 32/16 divider
module mul_div_unit (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // cpu access
    input wire mul_div_pkg::bus_req_type bus_req_in,
    output logic [15:0] bus_rdata_out,
    output logic bus_rvalid_out,
    // status
    output logic run_status_out,
    output logic muldiv_done_irq_out
);

    // declared first: the byte decode below is sized by it
    localparam int BYTE_COUNT_L = mul_div_pkg::BYTE_COUNT;

    // architectural registers
    logic [31:0] operand_result_reg;
    logic [15:0] remainder_reg;
    logic [15:0] divisor_multiplier_reg;
    logic mode_select_bit;
    mul_div_pkg::unit_state_type state;

    // next values
    logic [31:0] next_operand_result;
    logic [15:0] next_remainder;
    logic [15:0] next_divisor;
    logic next_mode;
    mul_div_pkg::unit_state_type next_state;
    logic next_done;
    logic [15:0] next_rdata;

    // decode
    logic [15:0] offset;
    logic [BYTE_COUNT_L-1:0] byte_we;
    logic [7:0] wbyte [BYTE_COUNT_L];
    logic [8*BYTE_COUNT_L-1:0] all_bytes;
    logic op_run_bit;
    logic ctrl_we;
    logic start;
    logic stop;
    logic step_active;
    logic step_last;
    logic mult_start;
    logic [5:0] step_limit;
    logic [31:0] base_operand;
    logic [15:0] base_divisor;
    mul_div_pkg::step_data_type step_cur;
    mul_div_pkg::step_data_type step_next;
    logic [7:0] rd_lo;
    logic [7:0] rd_hi;

    // a byte is hit by a narrow access at its address or a wide aligned one
    function automatic logic byte_hit(input logic [15:0] offs,
                                      input logic wide,
                                      input logic [15:0] idx);
        logic hit;
        hit = 1'b0;
        if (wide) begin
            hit = (offs[0] == 1'b0) && (offs[15:1] == idx[15:1]);
        end else begin
            hit = (offs == idx);
        end
        return hit;
    endfunction

    // unmapped bytes read as zero
    function automatic logic [7:0] read_byte(input logic [15:0] offs,
                                             input logic [71:0] bytes);
        logic [7:0] val;
        val = 8'h00;
        if (offs < 16'(BYTE_COUNT_L)) begin
            val = bytes[offs[3:0]*8 +: 8];
        end
        return val;
    endfunction

    // offset wraps high for addresses below the block, which reads as a miss
    assign offset = 16'(bus_req_in.addr - mul_div_pkg::REMAINDER_ADDR);

    // per-byte write strobes and data lanes
    for (genvar i = 0; i < BYTE_COUNT_L; i++) begin : g_lane
        assign byte_we[i] = bus_req_in.wr &&
            byte_hit(offset, bus_req_in.wide, 16'(i));
        assign wbyte[i] = (bus_req_in.wide && (i % 2 == 1)) ?
            bus_req_in.wdata[15:8] : bus_req_in.wdata[7:0];
    end

    // byte image of the register set as software sees it
    assign op_run_bit = (state != mul_div_pkg::ST_IDLE);
    assign all_bytes = {
        op_run_bit, 6'h00, mode_select_bit,
        divisor_multiplier_reg,
        operand_result_reg,
        remainder_reg
    };

    // control writes: a one in the run bit starts, a zero stops
    assign ctrl_we = byte_we[mul_div_pkg::CONTROL_IDX];
    assign start = ctrl_we &&
        wbyte[mul_div_pkg::CONTROL_IDX][mul_div_pkg::RUN_BIT];
    assign stop = ctrl_we &&
        !wbyte[mul_div_pkg::CONTROL_IDX][mul_div_pkg::RUN_BIT];
    assign next_mode = ctrl_we ?
        wbyte[mul_div_pkg::CONTROL_IDX][mul_div_pkg::MODE_BIT] :
        mode_select_bit;
    assign mult_start = start && (next_mode == mul_div_pkg::MODE_MULT);

    // the start cycle only loads; stepping begins on the next clock
    assign step_active = op_run_bit && !start;
    assign step_limit = (state == mul_div_pkg::ST_MULT) ?
        mul_div_pkg::MULT_CYCLES :
        mul_div_pkg::DIV_CYCLES;

    // state: restart beats everything, a stop aborts, the last step ends
    assign next_state = start ?
        (mult_start ? mul_div_pkg::ST_MULT : mul_div_pkg::ST_DIV) :
        ((stop || step_last) ? mul_div_pkg::ST_IDLE : state);

    // a completion that meets a clearing write still counts as done
    assign next_done = step_last;

    // arithmetic step on the live registers
    assign step_cur.operand = operand_result_reg;
    assign step_cur.remainder = remainder_reg;

    // operand before software bytes: clear high on a multiply start
    assign base_operand = mult_start ?
        {16'h0000, operand_result_reg[15:0]} :
        (step_active ? step_next.operand : operand_result_reg);

    // software bytes land last; while running that spoils the result
    for (genvar k = 0; k < 4; k++) begin : g_operand_byte
        assign next_operand_result[8*k +: 8] =
            byte_we[mul_div_pkg::OPERAND_IDX + k] ?
            wbyte[mul_div_pkg::OPERAND_IDX + k] :
            base_operand[8*k +: 8];
    end

    // divisor register: plain byte writes only
    assign base_divisor = divisor_multiplier_reg;
    for (genvar k = 0; k < 2; k++) begin : g_divisor_byte
        assign next_divisor[8*k +: 8] =
            byte_we[mul_div_pkg::DIVISOR_IDX + k] ?
            wbyte[mul_div_pkg::DIVISOR_IDX + k] :
            base_divisor[8*k +: 8];
    end

    // remainder: cleared at start, then follows the step; no write path
    assign next_remainder = start ? mul_div_pkg::REMAINDER_RESET :
        (step_active ? step_next.remainder : remainder_reg);

    // read mux: a wide read at an odd address returns zero
    assign rd_lo = read_byte(offset, all_bytes);
    assign rd_hi = offset[0] ? 8'h00 :
        read_byte(16'(offset + 16'h0001), all_bytes);
    assign next_rdata = bus_req_in.wide ?
        {rd_hi, (offset[0] ? 8'h00 : rd_lo)} :
        {8'h00, rd_lo};

    // one step of either operation
    mul_div_step u_step (
        .mult_in(state == mul_div_pkg::ST_MULT),
        .cur_in(step_cur),
        .divisor_in(divisor_multiplier_reg),
        .next_out(step_next)
    );

    // step counter, cleared by every start
    step_counter #(
        .WIDTH(mul_div_pkg::STEP_WIDTH)
    ) u_counter (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in),
        .clear_in(start),
        .enable_in(step_active),
        .limit_in(step_limit),
        .last_out(step_last)
    );

    // data registers
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            operand_result_reg <= mul_div_pkg::OPERAND_RESULT_RESET;
            remainder_reg <= mul_div_pkg::REMAINDER_RESET;
            divisor_multiplier_reg <= mul_div_pkg::DIVISOR_RESET;
        end else begin
            operand_result_reg <= next_operand_result;
            remainder_reg <= next_remainder;
            divisor_multiplier_reg <= next_divisor;
        end
    end

    // control state
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state <= mul_div_pkg::ST_IDLE;
            mode_select_bit <= mul_div_pkg::CONTROL_RESET[0];
        end else begin
            state <= next_state;
            mode_select_bit <= next_mode;
        end
    end

    // outputs, all registered
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            bus_rdata_out <= mul_div_pkg::RDATA_RESET;
            bus_rvalid_out <= 1'b0;
            run_status_out <= 1'b0;
            muldiv_done_irq_out <= 1'b0;
        end else begin
            bus_rdata_out <= bus_req_in.rd ? next_rdata : bus_rdata_out;
            bus_rvalid_out <= bus_req_in.rd;
            run_status_out <= (next_state != mul_div_pkg::ST_IDLE);
            muldiv_done_irq_out <= next_done;
        end
    end

endmodule

/* File: rtl/mul_div_pkg.sv */
// Overview of operation
// - multiplication mode gives the full 32-bit product of two unsigned 16-bit operands
// - division mode divides unsigned 32-bit dividend by 16-bit divisor, quotient and remainder
// - remainder_reg holds zero after multiplying and the remainder after dividing
// - remainder_reg is read by 8-bit or 16-bit access and ignores writes
// - reset clears remainder_reg to zero
// - starting an operation by setting op_run_bit clears remainder_reg
// - remainder_reg read while op_run_bit is set shows intermediate data
// - operand_result_reg is 32 bits, high and low halves, operand in and result out
// - a multiplication start clears operand_result_high
// - operand_result_reg read while running shows intermediate values
// - mode_select_bit at control bit 0: 0 divides, 1 multiplies
// - multiply uses low 16 bits of both registers, product fills all 32 bits
// - divide uses full operand_result_reg and divisor low 16 bits, writes quotient, remainder
// - operand_result_reg takes step results from the clock after start, every clock
// - operand_result halves are writable by 8-bit or 16-bit access, reset to zero
// - control holds op_run_bit at bit 7, mode at bit 0, others zero, resets zero
// - multiplication completes 16 clocks after start
// - division completes 32 clocks after start
// - on completion op_run_bit clears by itself and muldiv_done_irq is raised on the same clock
package mul_div_pkg;

    // byte addresses of the register set
    localparam logic [15:0] REMAINDER_ADDR = 16'hff60;
    localparam logic [15:0] OPERAND_RESULT_ADDR = 16'hff62;
    localparam logic [15:0] DIVISOR_MULT_ADDR = 16'hff66;
    localparam logic [15:0] CONTROL_ADDR = 16'hff68;

    // byte indices relative to REMAINDER_ADDR
    localparam int BYTE_COUNT = 9;
    localparam int REM_IDX = 0;
    localparam int OPERAND_IDX = 2;
    localparam int DIVISOR_IDX = 6;
    localparam int CONTROL_IDX = 8;

    // control register fields
    localparam int RUN_BIT = 7;
    localparam int MODE_BIT = 0;
    localparam logic MODE_DIV = 1'b0;
    localparam logic MODE_MULT = 1'b1;

    // values after reset
    localparam logic [31:0] OPERAND_RESULT_RESET = 32'h0000_0000;
    localparam logic [15:0] REMAINDER_RESET = 16'h0000;
    localparam logic [15:0] DIVISOR_RESET = 16'h0000;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [15:0] RDATA_RESET = 16'h0000;

    // step counts of one operation
    localparam int STEP_WIDTH = 6;
    localparam logic [5:0] MULT_CYCLES = 6'h10;
    localparam logic [5:0] DIV_CYCLES = 6'h20;

    // one cpu access: wide means a 16-bit access at an even address
    typedef struct packed {
        logic [15:0] addr;
        logic wr;
        logic rd;
        logic wide;
        logic [15:0] wdata;
    } bus_req_type;

    // working values passed through one arithmetic step
    typedef struct packed {
        logic [31:0] operand;
        logic [15:0] remainder;
    } step_data_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_MULT = 2'b01,
        ST_DIV = 2'b11
    } unit_state_type;

endpackage

/* File: rtl/mul_div_step.sv */
`timescale 1ns/100ps
// one shift-add or one restoring-subtract step, purely combinational
module mul_div_step (
    // control
    input wire logic mult_in,
    // working values
    input wire mul_div_pkg::step_data_type cur_in,
    input wire logic [15:0] divisor_in,
    output mul_div_pkg::step_data_type next_out
);

    logic [15:0] addend;
    logic [16:0] sum;
    logic [16:0] shifted;
    logic [16:0] diff;
    logic fits;

    // multiply: add b into the high half when the low lsb is set, then shift
    assign addend = cur_in.operand[0] ? divisor_in : 16'h0000;
    assign sum = {1'b0, cur_in.operand[31:16]} + {1'b0, addend};

    // divide: the partial remainder can reach 17 bits before the compare
    assign shifted = {cur_in.remainder, cur_in.operand[31]};
    assign fits = shifted >= {1'b0, divisor_in};
    assign diff = shifted - {1'b0, divisor_in};

    // a zero divisor always fits, so it just runs on to a meaningless answer
    assign next_out.operand = mult_in ?
        {sum, cur_in.operand[15:1]} :
        {cur_in.operand[30:0], fits};
    assign next_out.remainder = mult_in ?
        cur_in.remainder :
        (fits ? diff[15:0] : shifted[15:0]);

endmodule

/* File: rtl/step_counter.sv */
`timescale 1ns/100ps
// counts arithmetic steps and flags the final one
module step_counter #(
    parameter int WIDTH = mul_div_pkg::STEP_WIDTH
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // control
    input wire logic clear_in,
    input wire logic enable_in,
    input wire logic [WIDTH-1:0] limit_in,
    // status
    output logic last_out
);

    // the longest operation must fit in the counter
    if (WIDTH < mul_div_pkg::STEP_WIDTH) begin : g_width_check
        $error("step counter too narrow");
    end

    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;

    // a restart wins over a running count
    assign next_count = clear_in ? '0 :
        (enable_in ? WIDTH'(count + 1'b1) : count);
    assign last_out = enable_in && (count == WIDTH'(limit_in - 1'b1));

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

endmodule

/* File: verification/mul_div_unit_sva.sv */
`timescale 1ns/100ps
// port-level timing checks of the arithmetic unit
module mul_div_unit_sva (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // cpu access
    input wire mul_div_pkg::bus_req_type bus_req_in,
    input wire logic [15:0] bus_rdata_out,
    input wire logic bus_rvalid_out,
    // status
    input wire logic run_status_out,
    input wire logic muldiv_done_irq_out
);
    logic [5:0] cnt;
    logic mult_q;
    wire ctrl_wr;
    // a write that reaches the control byte
    assign ctrl_wr = bus_req_in.wr
        && bus_req_in.addr == mul_div_pkg::CONTROL_ADDR;
    // cycles since the last start; restart zeroes it like the design does
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt <= 6'h00;
            mult_q <= 1'b0;
        end else if (ctrl_wr && bus_req_in.wdata[7]) begin
            cnt <= 6'h00;
            mult_q <= bus_req_in.wdata[0];
        end else if (run_status_out) begin
            cnt <= cnt + 6'h01;
        end
    end
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);
    sequence start_seq;
        ctrl_wr && bus_req_in.wdata[7];
    endsequence
    // an abort write also drops run, so it is left out here
    sequence done_seq;
        $fell(run_status_out) && !$past(ctrl_wr);
    endsequence
    a_read_answers: assert property (
        bus_req_in.rd |=> bus_rvalid_out) else $error("read not answered");
    a_no_stray_valid: assert property (
        !bus_req_in.rd |=> !bus_rvalid_out) else $error("stray read valid");
    a_irq_one_cycle: assert property (
        muldiv_done_irq_out |=> !muldiv_done_irq_out)
        else $error("done pulse too long");
    a_irq_with_end: assert property (
        $rose(muldiv_done_irq_out) |-> $fell(run_status_out))
        else $error("done pulse without run clearing");
    a_start_sets_run: assert property (
        start_seq |=> run_status_out) else $error("start did not run");
    a_op_length: assert property (
        done_seq |-> cnt == (mult_q ? mul_div_pkg::MULT_CYCLES
        : mul_div_pkg::DIV_CYCLES)) else $error("wrong step count");
    a_idle_no_irq: assert property (
        !run_status_out |=> !muldiv_done_irq_out)
        else $error("done pulse while idle");
    a_rdata_holds: assert property (
        !bus_rvalid_out |-> $stable(bus_rdata_out))
        else $error("read data moved without a read");
endmodule

bind mul_div_unit mul_div_unit_sva i_mul_div_unit_sva (.*);

/* File: verification/test_mul_div_unit.sv */
`timescale 1ns/100ps
// reset values first, then the table of operations, then corner cases and a second reset by hand
module test_mul_div_unit;
    logic ref_clk_in;
    logic rst_b_in;
    mul_div_pkg::bus_req_type bus_req_in;
    logic [15:0] bus_rdata_out;
    logic bus_rvalid_out;
    logic run_status_out;
    logic muldiv_done_irq_out;
    int fails = 0;
    int tests_run = 0;
    int cycles = 0;
    typedef struct packed {
        logic mult;
        logic [31:0] a;
        logic [15:0] b;
        logic [31:0] q;
        logic [15:0] r;
    } row_type;
    row_type rows [6];

    mul_div_unit i_mul_div_unit (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in),
        .bus_req_in(bus_req_in),
        .bus_rdata_out(bus_rdata_out),
        .bus_rvalid_out(bus_rvalid_out),
        .run_status_out(run_status_out),
        .muldiv_done_irq_out(muldiv_done_irq_out)
    );

    initial begin
        ref_clk_in = 1'b0;
        forever #2 ref_clk_in = ~ref_clk_in;
    end

    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one access held for exactly one taking edge
    task automatic acc(logic w, logic [15:0] ad, logic wd, logic [15:0] d);
        @(posedge ref_clk_in);
        #1;
        bus_req_in = '{addr: ad, wr: w, rd: !w, wide: wd, wdata: d};
        @(posedge ref_clk_in);
        #1;
        bus_req_in = '0;
    endtask

    task automatic rd(logic [15:0] ad, logic wd, logic [15:0] e, string s);
        acc(1'b0, ad, wd, 16'h0000);
        check("rvalid", 32'h1, {31'h0, bus_rvalid_out});
        check(s, {16'h0, e}, {16'h0, bus_rdata_out});
    endtask

    // start, then count cycles until run clears by itself
    task automatic run_op(logic m, int steps);
        int n;
        n = 0;
        acc(1'b1, 16'hff68, 1'b0, {8'h00, 1'b1, 6'h00, m});
        while (run_status_out === 1'b1 && n < 40) begin
            @(posedge ref_clk_in);
            #1;
            n++;
        end
        check("steps", 32'(steps), 32'(n));
        check("irq", 32'h1, {31'h0, muldiv_done_irq_out});
    endtask

    initial begin
        bus_req_in = '0;
        rst_b_in = 1'b0;
        // mode, operand, divisor or multiplier, then result and remainder
        rows[0] = '{1'b1, 32'hdead_ffff, 16'hffff, 32'hfffe_0001, 16'h0000};
        rows[1] = '{1'b0, 32'hffff_ffff, 16'hffff, 32'h0001_0001, 16'h0000};
        rows[2] = '{1'b1, 32'h0000_00da, 16'h0093, 32'h0000_7d2e, 16'h0000};
        rows[3] = '{1'b0, 32'h1234_5678, 16'h0007, 32'h0299_c335, 16'h0005};
        rows[4] = '{1'b1, 32'h0000_1234, 16'h0000, 32'h0000_0000, 16'h0000};
        rows[5] = '{1'b0, 32'h0000_0007, 16'h0003, 32'h0000_0002, 16'h0001};
        repeat (4) @(posedge ref_clk_in);
        #1;
        rst_b_in = 1'b1;
        rd(16'hff60, 1'b1, 16'h0000, "rem");
        rd(16'hff64, 1'b1, 16'h0000, "hi");
        rd(16'hff68, 1'b0, 16'h0000, "ctrl");
        foreach (rows[i]) begin
            acc(1'b1, 16'hff62, 1'b1, rows[i].a[15:0]);
            acc(1'b1, 16'hff64, 1'b1, rows[i].a[31:16]);
            acc(1'b1, 16'hff66, 1'b1, rows[i].b);
            run_op(rows[i].mult, rows[i].mult ? 16 : 32);
            rd(16'hff62, 1'b1, rows[i].q[15:0], "lo");
            rd(16'hff64, 1'b1, rows[i].q[31:16], "hi");
            rd(16'hff60, 1'b1, rows[i].r, "rem");
        end
        // byte reads, a refused write to the remainder, an unmapped read
        rd(16'hff60, 1'b0, 16'h0001, "rem byte");
        acc(1'b1, 16'hff60, 1'b1, 16'hffff);
        rd(16'hff60, 1'b1, 16'h0001, "rem kept");
        rd(16'hff62, 1'b0, 16'h0002, "lo byte");
        rd(16'hff6a, 1'b1, 16'h0000, "unmapped");
        // restart while running must run the full count again
        acc(1'b1, 16'hff68, 1'b0, 16'h0081);
        rd(16'hff68, 1'b0, 16'h0081, "ctrl run");
        run_op(1'b1, 16);
        // clearing run aborts: no done pulse may follow
        acc(1'b1, 16'hff68, 1'b0, 16'h0080);
        acc(1'b1, 16'hff68, 1'b0, 16'h0000);
        repeat (36) begin
            check("abort irq", 32'h0, {31'h0, muldiv_done_irq_out});
            @(posedge ref_clk_in);
            #1;
        end
        // a zero divisor still ends normally
        acc(1'b1, 16'hff66, 1'b1, 16'h0000);
        run_op(1'b0, 32);
        // second reset in mid-run
        acc(1'b1, 16'hff62, 1'b1, 16'h00aa);
        acc(1'b1, 16'hff68, 1'b0, 16'h0081);
        rst_b_in = 1'b0;
        repeat (2) @(posedge ref_clk_in);
        #1;
        rst_b_in = 1'b1;
        check("run", 32'h0, {31'h0, run_status_out});
        rd(16'hff62, 1'b1, 16'h0000, "lo");
        rd(16'hff60, 1'b1, 16'h0000, "rem");
        test_done();
    end
endmodule
